// ==== rtl/wlan_pwr_pkg.sv ====
/*
 * Constants shared by the wireless module power mode controller: mode
 * encoding, register map and timing figures.
 * Assumes a 10 MHz bus clock and a 32 kHz low-rate control tick.
 */
package wlan_pwr_pkg;

   // ----------------------------------------------------------------
   // Operating modes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      M_OFF, M_OFFMODE, M_IDLE, M_SLEEP, M_DEEP, M_SCAN, M_AIRPLANE, M_TX
   } mode_type;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_RESCAN = 8'h08;
   localparam int CTRL_SLEEP_BIT = 0;
   localparam int CTRL_AIRPLANE_BIT = 1;
   localparam int STAT_POWERED_BIT = 4;
   localparam int STAT_IGN_BIT = 5;
   localparam int STAT_TXACT_BIT = 6;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [15:0] RESCAN_RESET = 16'h0100;
   localparam logic [31:0] RDATA_RESET = 32'h00000000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int LOW_HZ = 32_000;
   localparam int ON_MIN_MS = 500;
   localparam int ON_MAX_MS = 1500;
   localparam int OFF_MIN_MS = 2000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int ON_MIN_CYC = ON_MIN_MS * CYC_PER_MS;
   localparam int ON_MAX_CYC = ON_MAX_MS * CYC_PER_MS;
   localparam int OFF_MIN_CYC = OFF_MIN_MS * CYC_PER_MS;
   // Divider rounds down: the tick runs a hair above 32 kHz, never below
   localparam int TICK_DIV = CLK_HZ / LOW_HZ;
   localparam logic [8:0] TICK_LAST = 9'(TICK_DIV - 1);
   localparam logic [8:0] TICK_ZERO = 9'h000;
   localparam logic [31:0] CNT_ONE = 32'h00000001;
   localparam logic [15:0] RESCAN_ONE = 16'h0001;

endpackage : wlan_pwr_pkg

// ==== rtl/wlan_pwr_ctrl.sv ====
/*
 * Power mode controller of the wireless LAN module with an AHB-Lite
 * register slave. Assumes button and ignition inputs synchronous to hclk,
 * and radio status strobes (ap_lost, scan_ok, scan_fail) one cycle wide.
 */
`timescale 1ns/1ps

module wlan_pwr_ctrl
   import wlan_pwr_pkg::*;
#(
   parameter int ON_MIN = ON_MIN_CYC,
   parameter int ON_MAX = ON_MAX_CYC,
   parameter int OFF_MIN = OFF_MIN_CYC,
   parameter logic [15:0] RESCAN_INIT = RESCAN_RESET
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic power_button_n,
   input wire logic ignition_in,
   input wire logic ap_lost,
   input wire logic scan_ok,
   input wire logic scan_fail,
   input wire logic tx_busy,
   output logic powered,
   output logic cts_n,
   output logic dsr_n,
   output logic radio_tx_active_n,
   output logic radio_en,
   output logic if_en,
   output logic regulator_en,
   output logic slow_clk_sel,
   output logic [3:0] mode_state
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   mode_type mode_r, mode_nxt, prior_r;
   logic [1:0] ctrl_r;
   logic [15:0] rescan_r, deep_cnt_r;
   logic [31:0] press_cnt_r;
   logic btn_prev_r, ign_prev_r;
   logic [8:0] tick_cnt_r;
   logic wr_pend_r, rd_pend_r, hreadyout_r, hresp_r;
   logic [7:0] addr_r;
   logic [31:0] hrdata_r;
   logic powered_r, cts_n_r, dsr_n_r, txact_n_r, radio_en_r, if_en_r, regulator_en_r, slow_clk_sel_r;

   // ----------------------------------------------------------------
   // Low-rate tick and input events
   // ----------------------------------------------------------------
   wire slow_tick = (tick_cnt_r == TICK_LAST);
   wire btn_low = !power_button_n;
   wire btn_release = !btn_prev_r && power_button_n;
   wire is_on = (mode_r != M_OFF) && (mode_r != M_OFFMODE);
   wire on_press = btn_release && (press_cnt_r >= 32'(ON_MIN)) && (press_cnt_r <= 32'(ON_MAX));
   wire off_press = btn_low && (press_cnt_r == 32'(OFF_MIN - 1));
   wire ign_rise = ignition_in && !ign_prev_r;
   wire ign_fall = !ignition_in && ign_prev_r;
   wire pwr_off_evt = is_on && (off_press || ign_fall);
   wire rescan_due = slow_tick && ((deep_cnt_r + RESCAN_ONE) >= rescan_r);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_r <= TICK_ZERO;
         btn_prev_r <= 1'b1;
         ign_prev_r <= 1'b0;
         press_cnt_r <= '0;
      end else begin
         tick_cnt_r <= slow_tick ? TICK_ZERO : tick_cnt_r + 9'h001;
         btn_prev_r <= power_button_n;
         ign_prev_r <= ignition_in;
         // Saturates so a very long hold is never mistaken for a short one
         if (!btn_low) begin
            press_cnt_r <= '0;
         end else if (press_cnt_r < 32'(OFF_MIN)) begin
            press_cnt_r <= press_cnt_r + CNT_ONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // Mode sequencing
   // ----------------------------------------------------------------
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         M_OFF: begin
            if (on_press || ign_rise) begin
               mode_nxt = M_IDLE;
            end
         end
         M_OFFMODE: begin
            if (!ignition_in) begin
               mode_nxt = M_OFF;
            end else if (on_press) begin
               mode_nxt = M_IDLE;
            end
         end
         M_IDLE: begin
            if (tx_busy) begin
               mode_nxt = M_TX;
            end else if (ap_lost) begin
               mode_nxt = M_DEEP;
            end else if (ctrl_r[CTRL_AIRPLANE_BIT]) begin
               mode_nxt = M_AIRPLANE;
            end else if (ctrl_r[CTRL_SLEEP_BIT]) begin
               mode_nxt = M_SLEEP;
            end
         end
         M_SLEEP: begin
            if (tx_busy) begin
               mode_nxt = M_TX;
            end else if (ap_lost) begin
               mode_nxt = M_DEEP;
            end else if (!ctrl_r[CTRL_SLEEP_BIT]) begin
               mode_nxt = M_IDLE;
            end
         end
         M_DEEP: begin
            if (rescan_due) begin
               mode_nxt = M_SCAN;
            end
         end
         M_SCAN: begin
            if (scan_ok) begin
               mode_nxt = M_IDLE;
            end else if (scan_fail) begin
               mode_nxt = M_DEEP;
            end
         end
         M_AIRPLANE: begin
            if (!ctrl_r[CTRL_AIRPLANE_BIT]) begin
               mode_nxt = M_IDLE;
            end
         end
         M_TX: begin
            if (!tx_busy) begin
               mode_nxt = prior_r;
            end
         end
         default: begin
            mode_nxt = M_OFF;
         end
      endcase
      // Shutdown overrides everything; the ignition level picks the target
      if (pwr_off_evt) begin
         mode_nxt = (ignition_in && !ign_fall) ? M_OFFMODE : M_OFF;
      end
   end

   // Per-mode enables, decoded from the next mode so outputs track mode_r
   wire nxt_on = (mode_nxt != M_OFF) && (mode_nxt != M_OFFMODE);
   wire nxt_if = (mode_nxt == M_IDLE) || (mode_nxt == M_AIRPLANE) || (mode_nxt == M_TX);
   wire nxt_radio = (mode_nxt == M_IDLE) || (mode_nxt == M_SLEEP) || (mode_nxt == M_SCAN) || (mode_nxt == M_TX);
   wire nxt_tx = (mode_nxt == M_TX);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_r <= M_OFF;
         prior_r <= M_IDLE;
         deep_cnt_r <= '0;
      end else begin
         mode_r <= mode_nxt;
         if (mode_nxt == M_TX && mode_r != M_TX) begin
            prior_r <= mode_r;
         end
         if (mode_r != M_DEEP || rescan_due) begin
            deep_cnt_r <= '0;
         end else if (slow_tick) begin
            deep_cnt_r <= deep_cnt_r + RESCAN_ONE;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         powered_r <= 1'b0;
         cts_n_r <= 1'b1;
         dsr_n_r <= 1'b1;
         txact_n_r <= 1'b1;
         radio_en_r <= 1'b0;
         if_en_r <= 1'b0;
         regulator_en_r <= 1'b0;
         slow_clk_sel_r <= 1'b0;
      end else begin
         powered_r <= nxt_on;
         cts_n_r <= !nxt_if;
         dsr_n_r <= !nxt_if;
         radio_en_r <= nxt_radio;
         if_en_r <= nxt_if;
         regulator_en_r <= (mode_nxt != M_OFF);
         slow_clk_sel_r <= (mode_nxt == M_OFFMODE);
         txact_n_r <= nxt_tx ? (txact_n_r ^ slow_tick) : 1'b1;
      end
   end

   assign powered = powered_r;
   assign cts_n = cts_n_r;
   assign dsr_n = dsr_n_r;
   assign radio_tx_active_n = txact_n_r;
   assign radio_en = radio_en_r;
   assign if_en = if_en_r;
   assign regulator_en = regulator_en_r;
   assign slow_clk_sel = slow_clk_sel_r;
   assign mode_state = mode_r;

   // ----------------------------------------------------------------
   // AHB-Lite slave: writes zero-wait, reads one wait state
   // ----------------------------------------------------------------
   // The read wait state avoids returning stale data right after a write
   wire addr_ok = hsel && htrans[1] && hready;
   wire wr_ctrl = wr_pend_r && (addr_r == REG_CTRL);
   wire wr_rescan = wr_pend_r && (addr_r == REG_RESCAN);
   wire [31:0] status_val = {25'h0, !txact_n_r, ignition_in, powered_r, mode_r};
   wire [31:0] rd_val = (addr_r == REG_CTRL) ? {30'h0, ctrl_r} :
                        (addr_r == REG_STATUS) ? status_val :
                        (addr_r == REG_RESCAN) ? {16'h0, rescan_r} : 32'h00000000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r <= 8'h00;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
         hrdata_r <= RDATA_RESET;
      end else begin
         wr_pend_r <= addr_ok && hwrite;
         rd_pend_r <= addr_ok && !hwrite;
         hreadyout_r <= !(addr_ok && !hwrite);
         hresp_r <= 1'b0;
         if (addr_ok) begin
            addr_r <= {haddr[7:2], 2'h0};
         end
         if (rd_pend_r) begin
            hrdata_r <= rd_val;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= CTRL_RESET;
         rescan_r <= RESCAN_INIT;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= hwdata[1:0];
         end
         if (wr_rescan) begin
            rescan_r <= hwdata[15:0];
         end
      end
   end

   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign hrdata = hrdata_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_tx_enter;
      (mode_r == M_IDLE || mode_r == M_SLEEP) && tx_busy && !pwr_off_evt;
   endsequence
   sequence s_tx_leave;
      (mode_r == M_TX) && !tx_busy && !pwr_off_evt;
   endsequence

   AST_OFF_QUIET: assert property ((mode_r == M_OFF) |-> !regulator_en_r && !if_en_r && !radio_en_r)
      else $error("powered off with something enabled");
   AST_OFFMODE_ENTRY: assert property (is_on && off_press && ignition_in && ign_prev_r |=> mode_r == M_OFFMODE)
      else $error("button shutdown with ignition high missed off-mode");
   AST_OFFMODE_SLOW: assert property ((mode_r == M_OFFMODE) |-> regulator_en_r && slow_clk_sel_r && !if_en_r)
      else $error("off-mode enables wrong");
   AST_SLEEP_OUT: assert property ((mode_r == M_SLEEP) |-> powered_r && cts_n_r && !if_en_r && radio_en_r)
      else $error("sleep outputs wrong");
   AST_DEEP_ENTRY: assert property ((mode_r == M_IDLE) && ap_lost && !tx_busy && !pwr_off_evt
      |=> (mode_r == M_DEEP) && powered_r && cts_n_r)
      else $error("lost access point did not enter deep sleep");
   AST_RESCAN_FAIL: assert property ((mode_r == M_SCAN) && scan_fail && !scan_ok && !pwr_off_evt
      |=> mode_r == M_DEEP)
      else $error("failed rescan did not return to deep sleep");
   AST_RESCAN_OK: assert property ((mode_r == M_SCAN) && scan_ok && !pwr_off_evt |=> mode_r == M_IDLE)
      else $error("successful rescan did not leave deep sleep");
   AST_DEEP_RADIO: assert property ((mode_r == M_DEEP) |-> !radio_en_r)
      else $error("radio enabled between rescans");
   AST_IDLE_OUT: assert property ((mode_r == M_IDLE) |-> powered_r && !cts_n_r && !dsr_n_r)
      else $error("idle outputs wrong");
   AST_BOOT_IDLE: assert property ((mode_r == M_OFF) && (on_press || ign_rise) ##1 1'b1 |-> mode_r == M_IDLE)
      else $error("power-up did not settle in idle");
   AST_AIRPLANE: assert property ((mode_r == M_AIRPLANE) |-> if_en_r && !radio_en_r)
      else $error("airplane enables wrong");
   AST_TX_TOGGLE: assert property ((mode_r == M_TX) && slow_tick && tx_busy && !pwr_off_evt
      |=> powered_r && (radio_tx_active_n != $past(radio_tx_active_n)))
      else $error("transmit activity did not toggle");
   AST_TX_RETURN: assert property (s_tx_enter ##1 s_tx_leave |=> mode_r == $past(mode_r, 2))
      else $error("transmit did not return to prior mode");
   AST_PWR_IND: assert property (powered_r == is_on)
      else $error("powered indicator disagrees with mode");
   AST_LONG_OFF: assert property (is_on && off_press |=> !powered_r)
      else $error("long press did not power off");
   AST_IGN_DROP: assert property (is_on && ign_fall |=> mode_r == M_OFF)
      else $error("ignition drop did not power down");

endmodule : wlan_pwr_ctrl

// ==== test/host_model.sv ====
/*
 * Behavioural host processor driving the power button and ignition lines.
 * Assumes the bench calls its tasks just after a rising edge of hclk.
 */
`timescale 1ns/1ps

module host_model (
   input wire logic hclk,
   output logic power_button_n,
   output logic ignition_in
);
   // ----------------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------------
   // Button rests at its pull-up level, ignition low while unused
   initial begin
      power_button_n = 1'b1;
      ignition_in = 1'b0;
   end

   // ----------------------------------------------------------------
   // Host actions
   // ----------------------------------------------------------------
   task automatic press(input int n);
      power_button_n <= 1'b0;
      repeat (n) @(posedge hclk);
      power_button_n <= !power_button_n;
   endtask : press

   task automatic set_ign(input logic v);
      ignition_in <= v;
      @(posedge hclk);
   endtask : set_ign
endmodule : host_model

// ==== test/tb_wlan_pwr_ctrl.sv ====
/*
 * Self-checking bench of the power mode controller: AHB-Lite register
 * tasks, host model for button and ignition, radio strobes from the bench.
 * Assumes shortened press counts and a short rescan interval.
 */
`timescale 1ns/1ps

module tb_wlan_pwr_ctrl
   import wlan_pwr_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, ap_lost, scan_ok, scan_fail, tx_busy;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic hreadyout, hresp, powered, cts_n, dsr_n, radio_tx_active_n;
   wire logic radio_en, if_en, regulator_en, slow_clk_sel, power_button_n, ignition_in;
   wire logic [31:0] hrdata;
   wire logic [3:0] mode_state;
   int error_cnt, samples_checked, n;

   wlan_pwr_ctrl #(.ON_MIN(20), .ON_MAX(60), .OFF_MIN(80), .RESCAN_INIT(16'h0002)) i_wlan_pwr_ctrl (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .power_button_n(power_button_n), .ignition_in(ignition_in), .ap_lost(ap_lost),
      .scan_ok(scan_ok), .scan_fail(scan_fail), .tx_busy(tx_busy), .powered(powered), .cts_n(cts_n),
      .dsr_n(dsr_n), .radio_tx_active_n(radio_tx_active_n), .radio_en(radio_en), .if_en(if_en),
      .regulator_en(regulator_en), .slow_clk_sel(slow_clk_sel), .mode_state(mode_state));

   host_model i_host_model (.hclk(hclk), .power_button_n(power_button_n), .ignition_in(ignition_in));

   // ----------------------------------------------------------------
   // Reporting
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("Checks %0d, errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tmo;
      error_cnt++;
      $display("Error at %0t: wait ran out", $time);
      give_verdict();
   endtask : tmo

   // ----------------------------------------------------------------
   // Bus and mode helpers
   // ----------------------------------------------------------------
   // Values are sampled right after the edge, before the design's updates land
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k = 0;
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do begin
         @(posedge hclk);
         k++;
         if (k > 20) tmo();
      end while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
         if (k > 20) tmo();
      end while (hreadyout !== 1'b1);
      rd = hrdata;
      chk({31'h00000000, hresp}, 32'h00000000);
   endtask : ahb

   // Radio status lines: tx_busy is a level, the other three are strobes
   task automatic set_radio(input logic busy, input logic lost, input logic ok, input logic fail);
      tx_busy <= busy;
      ap_lost <= lost;
      scan_ok <= ok;
      scan_fail <= fail;
   endtask : set_radio

   // Outputs change on the same edge as the mode, yet they are looked at one edge later
   task automatic go(input logic [3:0] m, input logic [6:0] o);
      int k = 0;
      while (mode_state !== m) begin
         @(posedge hclk);
         k++;
         if (k > 2000) tmo();
      end
      @(posedge hclk);
      chk({28'h0000000, mode_state}, {28'h0000000, m});
      chk({25'h0000000, powered, cts_n, dsr_n, if_en, radio_en, regulator_en, slow_clk_sel}, {25'h0000000, o});
   endtask : go

   // ----------------------------------------------------------------
   // Clock and scenarios
   // ----------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      set_radio(1'b0, 1'b0, 1'b0, 1'b0);
      error_cnt = 0;
      samples_checked = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      go(M_OFF, 7'h30);
      ahb(1'b0, REG_RESCAN, 32'h00000000);
      chk(rd, 32'h00000002);
      i_host_model.press(10);
      repeat (5) @(posedge hclk);
      go(M_OFF, 7'h30);
      i_host_model.press(30);
      go(M_IDLE, 7'h4E);
      ahb(1'b1, REG_STATUS, 32'hFFFFFFFF);
      ahb(1'b0, REG_STATUS, 32'h00000000);
      chk(rd, 32'h00000012);
      ahb(1'b0, 8'h0C, 32'h00000000);
      chk(rd, 32'h00000000);
      ahb(1'b1, REG_CTRL, 32'h00000001);
      go(M_SLEEP, 7'h76);
      set_radio(1'b1, 1'b0, 1'b0, 1'b0);
      go(M_TX, 7'h4E);
      n = 0;
      while (radio_tx_active_n !== 1'b0) begin
         @(posedge hclk);
         n++;
         if (n > 700) tmo();
      end
      chk({31'h00000000, radio_tx_active_n}, 32'h00000000);
      ahb(1'b0, REG_STATUS, 32'h00000000);
      chk(rd, 32'h00000057);
      set_radio(1'b0, 1'b0, 1'b0, 1'b0);
      go(M_SLEEP, 7'h76);
      chk({31'h00000000, radio_tx_active_n}, 32'h00000001);
      ahb(1'b1, REG_CTRL, 32'h00000002);
      go(M_AIRPLANE, 7'h4A);
      ahb(1'b1, REG_CTRL, 32'h00000000);
      go(M_IDLE, 7'h4E);
      // One-cycle transmission from idle: one edge in transmit, then back
      set_radio(1'b1, 1'b0, 1'b0, 1'b0);
      @(posedge hclk);
      set_radio(1'b0, 1'b0, 1'b0, 1'b0);
      @(posedge hclk);
      chk({28'h0000000, mode_state}, {28'h0000000, M_TX});
      @(posedge hclk);
      go(M_IDLE, 7'h4E);
      ahb(1'b1, REG_RESCAN, 32'hFFFF0003);
      ahb(1'b0, REG_RESCAN, 32'h00000000);
      chk(rd, 32'h00000003);
      set_radio(1'b0, 1'b1, 1'b0, 1'b0);
      @(posedge hclk);
      set_radio(1'b0, 1'b0, 1'b0, 1'b0);
      go(M_DEEP, 7'h72);
      go(M_SCAN, 7'h76);
      set_radio(1'b0, 1'b0, 1'b0, 1'b1);
      @(posedge hclk);
      set_radio(1'b0, 1'b0, 1'b0, 1'b0);
      go(M_DEEP, 7'h72);
      go(M_SCAN, 7'h76);
      set_radio(1'b0, 1'b0, 1'b1, 1'b0);
      @(posedge hclk);
      set_radio(1'b0, 1'b0, 1'b0, 1'b0);
      go(M_IDLE, 7'h4E);
      i_host_model.set_ign(1'b1);
      i_host_model.press(100);
      go(M_OFFMODE, 7'h33);
      ahb(1'b0, REG_STATUS, 32'h00000000);
      chk(rd, 32'h00000021);
      i_host_model.press(30);
      go(M_IDLE, 7'h4E);
      i_host_model.press(100);
      go(M_OFFMODE, 7'h33);
      i_host_model.set_ign(1'b0);
      go(M_OFF, 7'h30);
      i_host_model.set_ign(1'b1);
      go(M_IDLE, 7'h4E);
      // Mid-run reset with ignition high: off during reset, up again one edge after release
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({28'h0000000, mode_state}, {28'h0000000, M_OFF});
      chk({25'h0000000, powered, cts_n, dsr_n, if_en, radio_en, regulator_en, slow_clk_sel}, 32'h00000030);
      hresetn <= 1'b1;
      go(M_IDLE, 7'h4E);
      i_host_model.set_ign(1'b0);
      go(M_OFF, 7'h30);
      give_verdict();
   end
endmodule : tb_wlan_pwr_ctrl
